// *** logic/ddp_gain_trim.sv ***
// Channel gain trim, 16 steps of 0.05 dB from +0.4 dB down
`timescale 1ns/100ps
module ddp_gain_trim (
    input  wire logic       pclk,     // System clock
    input  wire logic       presetn,  // Async reset, active low
    input  wire logic       en,       // Update this cycle
    input  wire logic [3:0] code,     // Trim code
    input  wire logic [9:0] din,      // Offset binary sample
    output logic      [9:0] dout      // Trimmed sample
);
    // Gain factors in Q2.14; a table avoids a log multiplier
    function automatic logic [15:0] coef(input logic [3:0] c);
        case (c)
            4'h0: coef = 16'h4304;
            4'h1: coef = 16'h42A2;
            4'h2: coef = 16'h4240;
            4'h3: coef = 16'h41DE;
            4'h4: coef = 16'h417E;
            4'h5: coef = 16'h411E;
            4'h6: coef = 16'h40BE;
            4'h7: coef = 16'h405F;
            4'h8: coef = 16'h4000;
            4'h9: coef = 16'h3FA2;
            4'hA: coef = 16'h3F44;
            4'hB: coef = 16'h3EE8;
            4'hC: coef = 16'h3E8B;
            4'hD: coef = 16'h3E2F;
            4'hE: coef = 16'h3DD4;
            default: coef = 16'h3D79;
        endcase
    endfunction

    logic signed [10:0] centred;
    logic signed [27:0] prod;
    logic signed [13:0] scaled;

    assign centred = $signed({1'b0, din}) - 11'sh200;
    assign prod    = 28'(centred * $signed({1'b0, coef(code)}));
    assign scaled  = 14'(prod >>> 14) + 14'sh200;

    // Saturate so full-scale codes never wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dout <= ddp_pkg::MIDSCALE;
        end else if (en) begin
            if (scaled < 14'sh0) begin
                dout <= 10'h000;
            end else if (scaled > 14'sh3FF) begin
                dout <= 10'h3FF;
            end else begin
                dout <= scaled[9:0];
            end
        end
    end
endmodule // ddp_gain_trim

// *** logic/ddp_interp_stage.sv ***
// One 2x linear interpolation stage with bypass
`timescale 1ns/100ps
module ddp_interp_stage #(
    parameter int W = 10
) (
    input  wire logic         pclk,     // System clock
    input  wire logic         presetn,  // Async reset, active low
    input  wire logic         en_in,    // New input sample this cycle
    input  wire logic         en_out,   // Output update this cycle
    input  wire logic         bypass,   // Pass samples unchanged
    input  wire logic [W-1:0] din,      // Input sample
    output logic      [W-1:0] dout      // Output sample
);
    logic [W-1:0] cur_r;
    logic [W:0]   sum;

    assign sum = {1'b0, cur_r} + {1'b0, din};

    // Midpoint on the new-sample slot, then the sample itself
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_r <= '0;
            dout  <= '0;
        end else if (en_out) begin
            if (bypass) begin
                dout <= din;
            end else if (en_in) begin
                dout  <= sum[W:1];
                cur_r <= din;
            end else begin
                dout <= cur_r;
            end
        end
    end
endmodule // ddp_interp_stage

// *** logic/ddp_pkg.sv ***
// Shared constants for the dual converter control and data port
package ddp_pkg;
    // Sample and control word layout
    localparam int         SAMPLE_W      = 10;
    localparam int         CW_W          = 8;
    localparam int         CW_PD_BIT     = 9;
    localparam int         CW_EN_BIT     = 8;
    localparam int         CW_F2_BIT     = 7;
    localparam int         CW_F1_BIT     = 6;
    localparam int         CW_GAIN_MSB   = 5;
    localparam int         CW_GAIN_LSB   = 2;
    localparam logic [7:0] CW_RESET      = 8'h48;  // Normal, 1x, gain 0 dB
    localparam logic [3:0] GAIN_0DB      = 4'h8;
    localparam logic [9:0] MIDSCALE      = 10'h200;
    // Timing
    localparam int         CLK_PERIOD_NS = 10;
    localparam int         WAKE_TIME_NS  = 700;
    localparam int         WAKE_CYCLES   = WAKE_TIME_NS / CLK_PERIOD_NS;  // Longest time, down
    // Register map, byte addresses
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_CWORD     = 8'h04;
    localparam logic [7:0] REG_STATUS    = 8'h08;
    localparam logic [7:0] REG_IRQ_STAT  = 8'h0C;
    localparam logic [7:0] REG_IRQ_MASK  = 8'h10;
    localparam int         CTRL_OUT_EN   = 0;
    localparam logic [0:0] CTRL_RESET    = 1'h1;
    localparam int         IRQ_W         = 4;
    localparam int         IRQ_CW        = 0;
    localparam int         IRQ_ILLEGAL   = 1;
    localparam int         IRQ_LOCK      = 2;
    localparam int         IRQ_WAKE      = 3;
    localparam logic [3:0] IRQ_MASK_RST  = 4'h0;
    // Operating states and interpolation factors
    typedef enum logic [1:0] {OP_NORMAL, OP_STANDBY, OP_PDOWN, OP_WAKE} ddp_op_t;
    typedef enum logic [1:0] {IP_X1, IP_X2, IP_X4} ddp_interp_t;
endpackage

// *** logic/ddp_top.sv ***
// Control word capture, clock enables, interpolation and APB registers
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/100ps
module ddp_top #(
    parameter int LOCK_CYCLES = 256,  // Multiplier settling time in cycles
    parameter int DAC_DIV     = 2     // pclk cycles per converter update
) (
    input  wire logic        pclk,                  // 100 MHz clock
    input  wire logic        presetn,               // Async reset, active low
    input  wire logic        psel,                  // APB select
    input  wire logic        penable,               // APB enable
    input  wire logic        pwrite,                // APB write
    input  wire logic [7:0]  paddr,                 // APB byte address
    input  wire logic [31:0] pwdata,                // APB write data
    output logic      [31:0] prdata,                // APB read data
    output logic             pready,                // APB ready
    output logic             pslverr,               // APB error
    input  wire logic [9:0]  port_a_data,           // Port A pins
    input  wire logic [9:0]  port_b_data,           // Port B pins
    input  wire logic        control_word_strobe_n, // Control word strobe
    input  wire logic        pll_enable_pin,        // Multiplier enable pin
    input  wire logic        interleave_select,     // Both channels on port A
    input  wire logic        ref_enable_n,          // Reference enable pin
    output logic             pll_locked,            // Multiplier lock
    output logic             ref_active,            // Reference running
    output logic             sample_take,           // Input sample taken
    output logic             dac_update_en,         // Converter update pulse
    output logic      [9:0]  dac_a_code,            // Channel A code
    output logic      [9:0]  dac_b_code,            // Channel B code
    output logic             irq                    // Level interrupt
);
    localparam int LW = $clog2(LOCK_CYCLES + 1);
    localparam int DW = $clog2(DAC_DIV + 1);
    localparam int WW = $clog2(ddp_pkg::WAKE_CYCLES + 1);

    // Pin synchronisers: stage 1 is read only by stage 2
    logic [9:0] a_m, a_s, b_m, b_s;
    logic [3:0] pin_m, pin_s;
    logic       strobe_d;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_m      <= '0;
            a_s      <= '0;
            b_m      <= '0;
            b_s      <= '0;
            pin_m    <= 4'hF;
            pin_s    <= 4'hF;
            strobe_d <= 1'b1;
        end else begin
            a_m      <= port_a_data;
            a_s      <= a_m;
            b_m      <= port_b_data;
            b_s      <= b_m;
            pin_m    <= {control_word_strobe_n, pll_enable_pin, interleave_select, ref_enable_n};
            pin_s    <= pin_m;
            strobe_d <= pin_s[3];
        end
    end

    logic strobe_fall, pll_en, ileave;
    assign strobe_fall = strobe_d & ~pin_s[3];
    assign pll_en      = pin_s[2];
    assign ileave      = pin_s[1];
    assign ref_active  = ~pin_s[0];

    // Control word, held until the next strobe; bits 1..0 never stored
    logic [7:0] cw_r;
    logic       f2_in, f1_in, illegal;
    assign f2_in   = a_s[ddp_pkg::CW_F2_BIT];
    assign f1_in   = a_s[ddp_pkg::CW_F1_BIT];
    assign illegal = f2_in & ~f1_in;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cw_r <= ddp_pkg::CW_RESET;
        end else if (strobe_fall) begin
            cw_r <= a_s[ddp_pkg::CW_PD_BIT:ddp_pkg::CW_GAIN_LSB];
        end
    end

    // Interpolation factor; an illegal pair keeps the previous factor
    ddp_pkg::ddp_interp_t factor_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            factor_r <= ddp_pkg::IP_X1;
        end else if (strobe_fall && !illegal) begin
            if (f2_in) begin
                factor_r <= ddp_pkg::IP_X4;
            end else if (f1_in) begin
                factor_r <= ddp_pkg::IP_X2;
            end else begin
                factor_r <= ddp_pkg::IP_X1;
            end
        end
    end

    logic       pd_bit, en_bit;
    logic [3:0] gain_code;
    assign pd_bit    = cw_r[ddp_pkg::CW_PD_BIT - ddp_pkg::CW_GAIN_LSB];
    assign en_bit    = cw_r[ddp_pkg::CW_EN_BIT - ddp_pkg::CW_GAIN_LSB];
    assign gain_code = cw_r[3:0];

    // Operating state; any wake passes through a timed settle
    ddp_pkg::ddp_op_t op_r;
    logic [WW-1:0]    wake_cnt_r;
    logic             wake_done;
    assign wake_done = (op_r == ddp_pkg::OP_WAKE) && (wake_cnt_r == WW'(ddp_pkg::WAKE_CYCLES - 1));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_r       <= ddp_pkg::OP_NORMAL;
            wake_cnt_r <= '0;
        end else begin
            wake_cnt_r <= '0;
            case (op_r)
                ddp_pkg::OP_NORMAL, ddp_pkg::OP_WAKE: begin
                    if (pd_bit) begin
                        op_r <= ddp_pkg::OP_PDOWN;
                    end else if (!en_bit) begin
                        op_r <= ddp_pkg::OP_STANDBY;
                    end else if (op_r == ddp_pkg::OP_WAKE) begin
                        wake_cnt_r <= wake_cnt_r + 1'b1;
                        if (wake_done) begin
                            op_r <= ddp_pkg::OP_NORMAL;
                        end
                    end
                end
                ddp_pkg::OP_STANDBY, ddp_pkg::OP_PDOWN: begin
                    if (pd_bit) begin
                        op_r <= ddp_pkg::OP_PDOWN;
                    end else if (!en_bit) begin
                        op_r <= ddp_pkg::OP_STANDBY;
                    end else begin
                        op_r <= ddp_pkg::OP_WAKE;
                    end
                end
                default: op_r <= ddp_pkg::OP_NORMAL;
            endcase
        end
    end

    // Clock multiplier model: lock after a settle time, lost when bypassed
    logic [LW-1:0] lock_cnt_r;
    logic          locked_d;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_cnt_r <= '0;
            pll_locked <= 1'b0;
            locked_d   <= 1'b0;
        end else begin
            locked_d <= pll_locked;
            if (!pll_en || op_r == ddp_pkg::OP_PDOWN) begin
                lock_cnt_r <= '0;
                pll_locked <= 1'b0;
            end else if (lock_cnt_r == LW'(LOCK_CYCLES - 1)) begin
                pll_locked <= 1'b1;
            end else begin
                lock_cnt_r <= lock_cnt_r + 1'b1;
            end
        end
    end

    // Update-rate divider; bypassed multiplier means pins clock directly
    logic          clk_run, tick, fac4, in_en, s1_en;
    logic [DW-1:0] div_r;
    logic [1:0]    phase_r;
    assign clk_run = (!pll_en || pll_locked) && (op_r == ddp_pkg::OP_NORMAL);
    assign tick    = clk_run && (div_r == '0);
    assign fac4    = (factor_r == ddp_pkg::IP_X4);
    assign in_en   = tick && (phase_r == 2'h0);
    assign s1_en   = tick && (!fac4 || !phase_r[0]);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r   <= '0;
            phase_r <= 2'h0;
        end else if (!clk_run) begin
            div_r   <= '0;
            phase_r <= 2'h0;
        end else begin
            div_r <= (div_r == DW'(DAC_DIV - 1)) ? '0 : div_r + 1'b1;
            if (tick) begin
                case (factor_r)
                    ddp_pkg::IP_X4: phase_r <= phase_r + 2'h1;
                    ddp_pkg::IP_X2: phase_r <= {1'b0, ~phase_r[0]};
                    default:        phase_r <= 2'h0;
                endcase
            end
        end
    end

    // Input register then output latch on the next sample slot
    logic [9:0] in_a_r, in_b_r, lat_a_r, lat_b_r;
    logic       il_ph_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_a_r  <= ddp_pkg::MIDSCALE;
            in_b_r  <= ddp_pkg::MIDSCALE;
            lat_a_r <= ddp_pkg::MIDSCALE;
            lat_b_r <= ddp_pkg::MIDSCALE;
            il_ph_r <= 1'b0;
        end else if (in_en) begin
            lat_a_r <= in_a_r;
            lat_b_r <= in_b_r;
            if (ileave) begin
                il_ph_r <= ~il_ph_r;
                if (!il_ph_r) begin
                    in_a_r <= a_s;
                end else begin
                    in_b_r <= a_s;
                end
            end else begin
                il_ph_r <= 1'b0;
                in_a_r  <= a_s;
                in_b_r  <= b_s;
            end
        end
    end
    assign sample_take = in_en;

    // Two cascaded 2x stages per channel
    logic [9:0] s1_a, s1_b, s2_a, s2_b, trim_a;
    ddp_interp_stage #(.W(ddp_pkg::SAMPLE_W)) u_a1 (
        .pclk(pclk), .presetn(presetn), .en_in(in_en), .en_out(s1_en),
        .bypass(factor_r == ddp_pkg::IP_X1), .din(lat_a_r), .dout(s1_a));
    ddp_interp_stage #(.W(ddp_pkg::SAMPLE_W)) u_a2 (
        .pclk(pclk), .presetn(presetn), .en_in(s1_en), .en_out(tick),
        .bypass(!fac4), .din(s1_a), .dout(s2_a));
    ddp_interp_stage #(.W(ddp_pkg::SAMPLE_W)) u_b1 (
        .pclk(pclk), .presetn(presetn), .en_in(in_en), .en_out(s1_en),
        .bypass(factor_r == ddp_pkg::IP_X1), .din(lat_b_r), .dout(s1_b));
    ddp_interp_stage #(.W(ddp_pkg::SAMPLE_W)) u_b2 (
        .pclk(pclk), .presetn(presetn), .en_in(s1_en), .en_out(tick),
        .bypass(!fac4), .din(s1_b), .dout(s2_b));
    ddp_gain_trim u_trim (
        .pclk(pclk), .presetn(presetn), .en(tick), .code(gain_code),
        .din(s2_a), .dout(trim_a));

    // Converter outputs; midscale outside normal operation
    logic ctrl_out_en_r, tick_d;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_d     <= 1'b0;
            dac_a_code <= ddp_pkg::MIDSCALE;
            dac_b_code <= ddp_pkg::MIDSCALE;
        end else begin
            tick_d <= tick;
            if (!clk_run || !ctrl_out_en_r) begin
                dac_a_code <= ddp_pkg::MIDSCALE;
                dac_b_code <= ddp_pkg::MIDSCALE;
            end else if (tick_d) begin
                dac_a_code <= trim_a;
                dac_b_code <= s2_b;
            end
        end
    end
    assign dac_update_en = tick_d && clk_run && ctrl_out_en_r;

    // APB slave: no wait states, error on unmapped address
    logic       wr, rd_setup, mapped;
    logic [3:0] irq_stat_r, irq_mask_r, irq_set;
    assign pready  = 1'b1;
    assign mapped  = paddr inside {ddp_pkg::REG_CTRL, ddp_pkg::REG_CWORD, ddp_pkg::REG_STATUS,
                                   ddp_pkg::REG_IRQ_STAT, ddp_pkg::REG_IRQ_MASK};
    assign pslverr = psel && penable && !mapped;
    assign wr      = psel && penable && pwrite && mapped;
    assign rd_setup = psel && !penable && !pwrite;

    // Event sources; a set in the clearing cycle wins
    assign irq_set[ddp_pkg::IRQ_CW]      = strobe_fall;
    assign irq_set[ddp_pkg::IRQ_ILLEGAL] = strobe_fall && illegal;
    assign irq_set[ddp_pkg::IRQ_LOCK]    = pll_locked ^ locked_d;
    assign irq_set[ddp_pkg::IRQ_WAKE]    = wake_done && en_bit && !pd_bit;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~((wr && paddr == ddp_pkg::REG_IRQ_STAT) ?
                           pwdata[3:0] : 4'h0)) | irq_set;
        end
    end
    assign irq = |(irq_stat_r & irq_mask_r);

    // Writable registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_out_en_r <= ddp_pkg::CTRL_RESET[0];
            irq_mask_r    <= ddp_pkg::IRQ_MASK_RST;
        end else if (wr) begin
            if (paddr == ddp_pkg::REG_CTRL) begin
                ctrl_out_en_r <= pwdata[ddp_pkg::CTRL_OUT_EN];
            end
            if (paddr == ddp_pkg::REG_IRQ_MASK) begin
                irq_mask_r <= pwdata[3:0];
            end
        end
    end

    // Read data is loaded in the setup cycle, so it stands through the access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            case (paddr)
                ddp_pkg::REG_CTRL:     prdata <= {31'h0, ctrl_out_en_r};
                ddp_pkg::REG_CWORD:    prdata <= {24'h0, cw_r};
                ddp_pkg::REG_STATUS:   prdata <= {24'h0, ileave, ref_active, pll_en,
                                                  pll_locked, factor_r, op_r};
                ddp_pkg::REG_IRQ_STAT: prdata <= {28'h0, irq_stat_r};
                ddp_pkg::REG_IRQ_MASK: prdata <= {28'h0, irq_mask_r};
                default:               prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule // ddp_top

// *** testbench/ddp_monitor.sv ***
// Port-level assertions for the converter control and data port
`timescale 1ns/100ps
module ddp_monitor #(
    parameter int LOCK_CYCLES = 256,  // Lock time
    parameter int DAC_DIV     = 2     // Cycles per update
) (
    input wire logic       pclk,            // Clock
    input wire logic       presetn,         // Reset, active low
    input wire logic       pll_enable_pin,  // Multiplier pin
    input wire logic       pll_locked,      // Lock flag
    input wire logic       ref_enable_n,    // Reference pin
    input wire logic       ref_active,      // Reference flag
    input wire logic       sample_take,     // Input slot
    input wire logic       dac_update_en,   // Update pulse
    input wire logic [9:0] dac_a_code       // Channel A code
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Pins pass sync flops, so levels are judged only after a few steady samples
    property p_lock_en; $rose(pll_locked) |-> $past(pll_enable_pin, 4); endproperty
    a_lock_en: assert property (p_lock_en) else $error("lock without enable");
    property p_unlock; (!pll_enable_pin) [*4] |-> !pll_locked; endproperty
    a_unlock: assert property (p_unlock) else $error("lock while bypassed");
    property p_ref_on; (!ref_enable_n) [*4] |-> ref_active; endproperty
    a_ref_on: assert property (p_ref_on) else $error("reference off");
    property p_ref_off; ref_enable_n [*4] |-> !ref_active; endproperty
    a_ref_off: assert property (p_ref_off) else $error("reference on");
    property p_reset_mid; $rose(presetn) |-> dac_a_code == ddp_pkg::MIDSCALE; endproperty
    a_reset_mid: assert property (p_reset_mid) else $error("code not idle");
    property p_upd_pulse; dac_update_en |=> !dac_update_en; endproperty
    a_upd_pulse: assert property (p_upd_pulse) else $error("update too long");
    // A slot while the multiplier runs must wait for lock
    property p_take_lock;
        sample_take && $past(pll_enable_pin, 2) && $past(pll_enable_pin, 3)
            && $past(pll_enable_pin, 4) |-> pll_locked;
    endproperty
    a_take_lock: assert property (p_take_lock) else $error("slot before lock");
    property p_codes_stand;
        $changed(dac_a_code) |-> dac_update_en || $past(dac_update_en)
            || dac_a_code == ddp_pkg::MIDSCALE;
    endproperty
    a_codes_stand: assert property (p_codes_stand) else $error("code moved");
endmodule  // ddp_monitor

bind ddp_top ddp_monitor #(.LOCK_CYCLES(LOCK_CYCLES), .DAC_DIV(DAC_DIV)) u_mon (
    .pclk(pclk), .presetn(presetn), .pll_enable_pin(pll_enable_pin),
    .pll_locked(pll_locked), .ref_enable_n(ref_enable_n), .ref_active(ref_active),
    .sample_take(sample_take), .dac_update_en(dac_update_en), .dac_a_code(dac_a_code));

// *** testbench/ddp_source.sv ***
// Parallel sample source: steady samples and control word writes
`timescale 1ns/100ps
module ddp_source (
    input  wire logic       pclk,                  // Clock
    output logic      [9:0] port_a_data,           // Port A pins
    output logic      [9:0] port_b_data,           // Port B pins
    output logic            control_word_strobe_n  // Word strobe
);
    logic       busy = 1'b0;
    logic [9:0] word = 10'h000;
    // Steady samples make the output known; the device sets the pace
    assign port_a_data = busy ? word : 10'h2AA;
    assign port_b_data = 10'h155;
    initial control_word_strobe_n = 1'b1;
    // Data held three cycles before the fall and three after the rise; low bits set to show they are ignored
    task automatic send_cw(input logic [7:0] w);
        busy <= 1'b1;
        word <= {w, 2'b11};
        repeat (3) @(posedge pclk);
        control_word_strobe_n <= 1'b0;
        repeat (4) @(posedge pclk);
        control_word_strobe_n <= 1'b1;
        repeat (3) @(posedge pclk);
        busy <= 1'b0;
    endtask
endmodule  // ddp_source

// *** testbench/ddp_top_tb_top.sv ***
// Self-checking bench for the converter control and data port
`timescale 1ns/100ps
module ddp_top_tb_top;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        pll_en = 1'b0, ilv = 1'b0, ref_n = 1'b1, cnt_on = 1'b0, err;
    logic        pready, pslverr, stb_n, locked, ref_on, take, upd, irq;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [9:0]  pa, pb, dac_a, dac_b;
    int          n_mismatch = 0, total_checks = 0, n_take = 0, n_upd = 0, k;
    logic [7:0]  cw_tab [6] = '{8'h58, 8'h78, 8'h68, 8'h08, 8'h48, 8'h88};
    logic [31:0] st_tab [6] = '{32'h4, 32'h8, 32'h8, 32'h1, 32'h3, 32'h2};  // Factor, state

    ddp_top #(.LOCK_CYCLES(4), .DAC_DIV(2)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port_a_data(pa), .port_b_data(pb), .control_word_strobe_n(stb_n),
        .pll_enable_pin(pll_en), .interleave_select(ilv), .ref_enable_n(ref_n),
        .pll_locked(locked), .ref_active(ref_on), .sample_take(take), .dac_update_en(upd),
        .dac_a_code(dac_a), .dac_b_code(dac_b), .irq(irq));
    ddp_source src (.pclk(pclk), .port_a_data(pa), .port_b_data(pb),
        .control_word_strobe_n(stb_n));

    // Clock, 10 ns period
    initial forever #5 pclk = ~pclk;
    // Slot and update counts for the rate check
    always @(posedge pclk) if (cnt_on) begin
        n_take += int'(take);
        n_upd += int'(upd);
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // One APB transfer; the request stands until pready is seen at an edge, for at most 20 further edges
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        for (int n = 0; n < 20 && pready !== 1'b1; n++) @(posedge pclk);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        check("pready", 32'h1, {31'h0, pready});
        if (pready !== 1'b1) final_report();
    endtask

    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, exp, rd);
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge pclk);
        check("watchdog", 32'h0, 32'h1);
        final_report();
    end

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rchk("cword", ddp_pkg::REG_CWORD, 32'h48);
        rchk("status", ddp_pkg::REG_STATUS, 32'h0);
        rchk("ctrl", ddp_pkg::REG_CTRL, 32'h1);
        rchk("mask", ddp_pkg::REG_IRQ_MASK, 32'h0);
        apb(1'b0, 8'hFC, 32'h0);
        check("unmapped", 32'h1, {31'h0, err});
        // Every factor and state, an illegal filter pair and a wake from standby
        for (int i = 0; i < 6; i++) begin
            src.send_cw(cw_tab[i]);
            rchk("status", ddp_pkg::REG_STATUS, st_tab[i]);
            // An illegal filter pair still stores the rest of the word
            rchk("cword", ddp_pkg::REG_CWORD, {24'h0, cw_tab[i]});
            if (st_tab[i] == 32'h3) begin
                repeat (ddp_pkg::WAKE_CYCLES) @(posedge pclk);
                rchk("woken", ddp_pkg::REG_STATUS, 32'h0);
            end
        end
        rchk("irq stat", ddp_pkg::REG_IRQ_STAT, 32'hB);
        check("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, ddp_pkg::REG_IRQ_MASK, 32'h1);
        @(posedge pclk) check("irq on", 32'h1, {31'h0, irq});
        apb(1'b1, ddp_pkg::REG_IRQ_STAT, 32'h1);
        @(posedge pclk) check("irq clear", 32'h0, {31'h0, irq});
        src.send_cw(8'h48);
        repeat (80) @(posedge pclk);
        pll_en <= 1'b1;
        for (k = 0; k < 50 && locked !== 1'b1; k++) @(posedge pclk);
        check("locked", 32'h1, {31'h0, locked});
        if (locked !== 1'b1) final_report();
        repeat (60) @(posedge pclk);
        check("code a", 32'h2AA, {22'h0, dac_a});
        check("code b", 32'h155, {22'h0, dac_b});
        src.send_cw(8'h78);
        repeat (60) @(posedge pclk);
        cnt_on <= 1'b1;
        repeat (200) @(posedge pclk);
        cnt_on <= 1'b0;
        k = int'(n_take > 20 && n_upd >= 4 * n_take - 2 && n_upd <= 4 * n_take + 2);
        check("4x rate", 32'h1, k);
        check("code 4x", 32'h2AA, {22'h0, dac_a});
        // Trim code 0 is +0.4 dB: offset 170 above midscale grows to 178
        src.send_cw(8'h70);
        repeat (100) @(posedge pclk);
        check("code trim", 32'h2B2, {22'h0, dac_a});
        apb(1'b1, ddp_pkg::REG_CTRL, 32'h0);
        repeat (10) @(posedge pclk);
        check("muted", 32'h200, {22'h0, dac_a});
        ref_n <= 1'b0;
        ilv <= 1'b1;
        repeat (4) @(posedge pclk);
        check("ref on", 32'h1, {31'h0, ref_on});
        rchk("status", ddp_pkg::REG_STATUS, 32'hF8);
        // Interleaved, channel B takes its samples from port A, not port B
        apb(1'b1, ddp_pkg::REG_CTRL, 32'h1);
        repeat (120) @(posedge pclk);
        check("code b ilv", 32'h2AA, {22'h0, dac_b});
        pll_en <= 1'b0;
        repeat (6) @(posedge pclk);
        check("unlocked", 32'h0, {31'h0, locked});
        final_report();
    end
endmodule  // ddp_top_tb_top
